// file: core/spm_config_regs.sv
// Serial port power and pin/mode select configuration registers.
// Assumes host strobes on core_clk; base addresses come from neighbouring registers.
//
// How it works
// - Power register answers only in config mode at index 02h; powers up 88h.
// - Power register bits 0-2 and 4-6 always read zero.
// - Bit 3 high runs primary serial port; low powers it down.
// - Bit 7 high runs secondary serial port; low powers it down.
// - Power-down stops device and pins but keeps its address decoding.
// - Address decoding stops whenever the base address is below 100h.
// - Powered-down device at valid base still joins range checking.
// - Pin/mode register answers in config mode at index 03h; printed default 780h.
// - Bit 1 selects enhanced floppy mode 2; zero is normal mode.
// - Bit 4 high holds second density output high; low passes density.
// - Bits 6:5 pick interface mode: 11 AT, 10 reserved, 01, 00.
// - Registers keep values over host reset; reached through index/data ports.
`timescale 1ns/1ps
`default_nettype none

module spm_config_regs (
  // Clock and power-up reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // Host reset pin, leaves configuration untouched
  input  wire logic              host_reset_pin,
  // Host index/data port pair
  input  wire spm_pkg::host_req_t io_req,
  output logic [7:0]             io_rdata,
  output logic                   io_rvalid,
  // Base addresses of the two serial ports
  input  wire logic [9:0]        uart1_base,
  input  wire logic [9:0]        uart2_base,
  // Density signal from the floppy core
  input  wire logic              density_in,
  // Controls to the rest of the chip
  output spm_pkg::dev_ctrl_t     ctrl
);

  import spm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    cfg_state_t cfg;
    logic [7:0] index;
    logic [7:0] ser_pwr;
    logic [7:0] pin_mode;
    logic [7:0] rdata;
    logic       rvalid;
    dev_ctrl_t  ctrl;
  } regs_state_t;

  // Controls read zero while reset is held; all but cfg_active follow the registers and inputs one edge later
  localparam regs_state_t STATE_RESET = '{
    cfg:      CFG_IDLE,
    index:    8'h00,
    ser_pwr:  SER_PWR_RESET,
    pin_mode: PIN_MODE_RESET,
    rdata:    RDATA_IDLE,
    rvalid:   1'b0,
    ctrl:     '0
  };

  regs_state_t st;
  regs_state_t next_st;
  logic        host_reset;
  logic        data_wr;
  logic        data_rd;
  logic        idx_wr;
  logic        idx_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Base address valid for host decoding
  function automatic logic base_valid(input logic [9:0] base);
    return base >= BASE_MIN;
  endfunction

  // Readback of one register with reserved bits forced to zero
  function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                          input logic [7:0] sp,
                                          input logic [7:0] pm);
    logic [7:0] val;
    val = RDATA_IDLE;
    if (idx == IDX_SER_PWR) begin
      val = sp & SER_PWR_WMASK;
    end else if (idx == IDX_PIN_MODE) begin
      val = pm & PIN_MODE_WMASK;
    end
    return val;
  endfunction

  // Host reset pin crosses into core_clk
  // It is a pin, so it passes two flops before anything reads it
  spm_sync2 u_host_reset_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in (host_reset_pin),
    .sync_out (host_reset)
  );

  // Decode of the host strobes
  assign idx_wr  = io_req.wr && (io_req.port == IDX_PORT);
  assign idx_rd  = io_req.rd && (io_req.port == IDX_PORT);
  assign data_wr = io_req.wr && (io_req.port == DATA_PORT);
  assign data_rd = io_req.rd && (io_req.port == DATA_PORT);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;

    // Configuration mode key sequence on the index port
    unique case (st.cfg)
      CFG_IDLE: begin
        if (idx_wr && io_req.wdata == CFG_KEY_ENTER) begin
          next_st.cfg = CFG_KEY1;
        end
      end
      CFG_KEY1: begin
        if (idx_wr) begin
          next_st.cfg = (io_req.wdata == CFG_KEY_ENTER) ? CFG_ACTIVE : CFG_IDLE;
        end
      end
      CFG_ACTIVE: begin
        if (idx_wr && io_req.wdata == CFG_KEY_EXIT) begin
          next_st.cfg = CFG_IDLE;
        end else if (idx_wr) begin
          next_st.index = io_req.wdata;
        end
      end
      default: begin
        next_st.cfg = CFG_IDLE;
      end
    endcase

    // Data port writes land only in config mode
    // A write that races a host reset is dropped so the bank stays intact
    if (data_wr && st.cfg == CFG_ACTIVE && !host_reset) begin
      if (st.index == IDX_SER_PWR) begin
        next_st.ser_pwr = io_req.wdata & SER_PWR_WMASK;
      end else if (st.index == IDX_PIN_MODE) begin
        next_st.pin_mode = io_req.wdata & PIN_MODE_WMASK;
      end
    end

    // Reads answer one cycle later; outside config mode they show idle data
    // The index port answers with the index itself so software can confirm it
    if (data_rd || idx_rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = RDATA_IDLE;
      if (st.cfg == CFG_ACTIVE) begin
        next_st.rdata = idx_rd ? st.index : reg_read(st.index, st.ser_pwr, st.pin_mode);
      end
    end

    // Host reset leaves config mode but keeps the registers
    if (host_reset) begin
      next_st.cfg   = CFG_IDLE;
      next_st.index = 8'h00;
    end

    // Serial port run and decode controls
    // Decode ignores the power bits: a sleeping port still claims its range
    next_st.ctrl.cfg_active        = (next_st.cfg == CFG_ACTIVE);
    next_st.ctrl.uart_run[0]       = st.ser_pwr[UART1_PWR_BIT];
    next_st.ctrl.uart_run[1]       = st.ser_pwr[UART2_PWR_BIT];
    next_st.ctrl.uart_decode_en[0] = base_valid(uart1_base);
    next_st.ctrl.uart_decode_en[1] = base_valid(uart2_base);

    // Floppy and pin controls
    next_st.ctrl.second_density_output =
      st.pin_mode[DEN_FORCE_BIT] ? 1'b1 : density_in;
    next_st.ctrl.iface_mode =
      iface_mode_t'({st.pin_mode[IDENT_BIT], st.pin_mode[ENC_BIT]});
    next_st.ctrl.enhanced_floppy_mode2 = st.pin_mode[EFM2_BIT];
    next_st.ctrl.pin_func_game_select  = st.pin_mode[PIN_FUNC_BIT];
    next_st.ctrl.pin94_sel =
      {st.pin_mode[PIN94_HI_BIT], st.pin_mode[PIN94_LO_BIT]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; only power-up reset sets the defaults

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign io_rdata  = st.rdata;
  assign io_rvalid = st.rvalid;
  assign ctrl      = st.ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (!arst_n);

  sequence cfg_data_rd(logic [7:0] idx);
    data_rd && st.cfg == CFG_ACTIVE && st.index == idx;
  endsequence

  ser_access_gate_a: assert property (
    data_wr && st.cfg != CFG_ACTIVE |=> $stable(st.ser_pwr) && $stable(st.pin_mode))
    else $error("register changed outside config mode");

  ser_read_zero_a: assert property (
    cfg_data_rd(IDX_SER_PWR) |=> io_rvalid && io_rdata[2:0] == 3'h0
                                 && io_rdata[6:4] == 3'h0
                                 && io_rdata[3] == $past(st.ser_pwr[UART1_PWR_BIT]))
    else $error("power register readback wrong");

  uart1_power_a: assert property (
    !st.ser_pwr[UART1_PWR_BIT] ##1 !st.ser_pwr[UART1_PWR_BIT] |-> !ctrl.uart_run[0])
    else $error("primary port runs while powered down");

  uart2_write_a: assert property (
    data_wr && st.cfg == CFG_ACTIVE && st.index == IDX_SER_PWR && !host_reset
      |=> ##1 ctrl.uart_run[1] == $past(io_req.wdata[UART2_PWR_BIT], 2))
    else $error("secondary port run does not follow write");

  decode_kept_a: assert property (
    !ctrl.uart_run[0] && $past(arst_n) && $past(base_valid(uart1_base))
      |-> ctrl.uart_decode_en[0])
    else $error("decode lost on power down");

  decode_off_a: assert property (
    uart2_base < BASE_MIN |=> !ctrl.uart_decode_en[1])
    else $error("decode active below minimum base");

  range_check_a: assert property (
    base_valid(uart1_base) && !st.ser_pwr[UART1_PWR_BIT] |=> ctrl.uart_decode_en[0])
    else $error("powered-down port left range checking");

  pin_read_a: assert property (
    cfg_data_rd(IDX_PIN_MODE) |=> io_rvalid && io_rdata == ($past(st.pin_mode) & PIN_MODE_WMASK))
    else $error("pin mode readback wrong");

  // Controls sit at zero for one edge after release, so these start out of reset
  // and compare with the register value of the cycle before
  floppy_mode_a: assert property (
    arst_n |=> ctrl.enhanced_floppy_mode2 == $past(st.pin_mode[EFM2_BIT]))
    else $error("floppy mode does not follow bit 1");

  density_out_a: assert property (
    arst_n |=> ctrl.second_density_output ==
      ($past(st.pin_mode[DEN_FORCE_BIT]) ? 1'b1 : $past(density_in)))
    else $error("second density output wrong");

  iface_mode_a: assert property (
    arst_n |=> ctrl.iface_mode == iface_mode_t'($past(st.pin_mode[6:5])))
    else $error("interface mode does not follow bits 6:5");

  host_reset_keep_a: assert property (
    host_reset |=> $stable(st.ser_pwr) && $stable(st.pin_mode) && !ctrl.cfg_active)
    else $error("host reset disturbed configuration");

  rsvd_ignored_a: assert property (
    data_wr && st.cfg == CFG_ACTIVE |=> st.ser_pwr[2:0] == 3'h0
                                        && st.ser_pwr[6:4] == 3'h0 && !st.pin_mode[3])
    else $error("reserved bit took a write");

  uart1_write_a: assert property (
    data_wr && st.cfg == CFG_ACTIVE && st.index == IDX_SER_PWR && !host_reset
      |=> ##1 ctrl.uart_run[0] == $past(io_req.wdata[UART1_PWR_BIT], 2))
    else $error("primary port run does not follow write");

  decode_floor_a: assert property (
    uart1_base < BASE_MIN |=> !ctrl.uart_decode_en[0])
    else $error("primary decode active below minimum base");

  idle_read_a: assert property (
    data_rd && st.cfg != CFG_ACTIVE |=> io_rvalid && io_rdata == RDATA_IDLE)
    else $error("data read answered outside config mode");

  pin_write_a: assert property (
    data_wr && st.cfg == CFG_ACTIVE && st.index == IDX_PIN_MODE && !host_reset
      |=> st.pin_mode == ($past(io_req.wdata) & PIN_MODE_WMASK))
    else $error("pin mode write did not land");

  index_read_a: assert property (
    idx_rd && st.cfg == CFG_ACTIVE |=> io_rvalid && io_rdata == $past(st.index))
    else $error("index readback wrong");

  enter_cfg_c: cover property (st.cfg == CFG_KEY1 ##1 st.cfg == CFG_ACTIVE);
  uart_down_c: cover property (!ctrl.uart_run[0] && ctrl.uart_decode_en[0]);
  density_pass_c: cover property (!st.pin_mode[DEN_FORCE_BIT] ##1 !ctrl.second_density_output);
  exit_cfg_c: cover property (st.cfg == CFG_ACTIVE ##1 st.cfg == CFG_IDLE);
  host_reset_c: cover property (host_reset && st.cfg == CFG_ACTIVE);

endmodule

`default_nettype wire

// file: core/spm_pkg.sv
// Package for the serial power and pin/mode configuration block.
// Assumes a host bus front end on core_clk that hands over one-cycle strobes.

package spm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Host port pair and configuration mode keys
  localparam logic       IDX_PORT      = 1'b0;
  localparam logic       DATA_PORT     = 1'b1;
  localparam logic [7:0] CFG_KEY_ENTER = 8'h55;
  localparam logic [7:0] CFG_KEY_EXIT  = 8'haa;
  localparam logic [7:0] RDATA_IDLE    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port power register
  localparam logic [7:0] IDX_SER_PWR   = 8'h02;
  localparam logic [7:0] SER_PWR_RESET = 8'h88;
  localparam logic [7:0] SER_PWR_WMASK = 8'h88;
  localparam int         UART1_PWR_BIT = 3;
  localparam int         UART2_PWR_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Pin and mode select register
  localparam logic [7:0]  IDX_PIN_MODE       = 8'h03;
  localparam logic [11:0] PIN_MODE_PRINTED   = 12'h780;
  localparam logic [7:0]  PIN_MODE_WMASK     = 8'hf7;
  localparam logic [7:0]  PIN_MODE_RESET     = PIN_MODE_PRINTED[11:4] & PIN_MODE_WMASK;
  localparam int          PIN_FUNC_BIT       = 0;
  localparam int          EFM2_BIT           = 1;
  localparam int          PIN94_LO_BIT       = 2;
  localparam int          DEN_FORCE_BIT      = 4;
  localparam int          ENC_BIT            = 5;
  localparam int          IDENT_BIT          = 6;
  localparam int          PIN94_HI_BIT       = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Host address decoding
  localparam int          ADDR_W   = 10;
  localparam logic [9:0]  BASE_MIN = 10'h100;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    MODE_REDUCED    = 2'b00,
    MODE_SECOND_GEN = 2'b01,
    MODE_RSVD       = 2'b10,
    MODE_AT         = 2'b11
  } iface_mode_t;

  typedef enum logic [1:0] {
    CFG_IDLE   = 2'b00,
    CFG_KEY1   = 2'b01,
    CFG_ACTIVE = 2'b10
  } cfg_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       port;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic        cfg_active;
    logic [1:0]  uart_run;
    logic [1:0]  uart_decode_en;
    logic        second_density_output;
    iface_mode_t iface_mode;
    logic        enhanced_floppy_mode2;
    logic        pin_func_game_select;
    logic [1:0]  pin94_sel;
  } dev_ctrl_t;

endpackage

// file: core/spm_sync2.sv
// Two flip-flop synchroniser for one level from a pin.
// Assumes the level is slow against core_clk.
`timescale 1ns/1ps
`default_nettype none

module spm_sync2 (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic meta;
    logic q;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // Shift the pin level through two stages
  always_comb begin
    next_st.meta = async_in;
    next_st.q    = st.meta;
  end

  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.q;

endmodule

`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the serial power and pin/mode configuration registers.
// Assumes spm_pkg and spm_config_regs are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import spm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Design signals and bench state
  logic       core_clk       = 1'b0;
  logic       arst_n         = 1'b0;
  logic       host_reset_pin = 1'b0;
  host_req_t  io_req         = '0;
  logic [7:0] io_rdata;
  logic       io_rvalid;
  logic [9:0] uart1_base     = 10'h000;
  logic [9:0] uart2_base     = 10'h000;
  logic       density_in     = 1'b0;
  dev_ctrl_t  ctrl;
  int         fails          = 0;
  int         num_checks     = 0;
  logic [7:0] rv;
  logic [7:0] w;
  logic [7:0] sp_now;
  logic [7:0] pm_now;
  logic       cfg_now;

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  spm_config_regs dut (
    .core_clk       (core_clk),
    .arst_n         (arst_n),
    .host_reset_pin (host_reset_pin),
    .io_req         (io_req),
    .io_rdata       (io_rdata),
    .io_rvalid      (io_rvalid),
    .uart1_base     (uart1_base),
    .uart2_base     (uart2_base),
    .density_in     (density_in),
    .ctrl           (ctrl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Expected register contents after a write
  function automatic logic [7:0] exp_sp(input logic [7:0] d);
    return d & 8'h88;
  endfunction

  function automatic logic [7:0] exp_pm(input logic [7:0] d);
    return d & 8'hf7;
  endfunction

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Host port cycles: one-cycle strobes
  task automatic host_wr(input logic port, input logic [7:0] d);
    @(posedge core_clk) io_req <= '{wr: 1'b1, rd: 1'b0, port: port, wdata: d};
    @(posedge core_clk) io_req <= '0;
  endtask

  // Read answer is due on the same edge that takes the strobe, one cycle after it is driven
  task automatic host_rd(input logic port, output logic [7:0] d);
    @(posedge core_clk) io_req <= '{wr: 1'b0, rd: 1'b1, port: port, wdata: 8'h00};
    @(posedge core_clk) io_req <= '0;
    #1;
    chk(16'(io_rvalid), 16'h1);
    d = io_rdata;
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    host_wr(IDX_PORT, idx);
    host_wr(DATA_PORT, d);
  endtask

  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
    host_wr(IDX_PORT, idx);
    host_rd(DATA_PORT, d);
  endtask

  task automatic enter_cfg();
    host_wr(IDX_PORT, CFG_KEY_ENTER);
    host_wr(IDX_PORT, CFG_KEY_ENTER);
  endtask

  // Controls settle two cycles after the data strobe
  task automatic check_ctrl();
    repeat (3) @(posedge core_clk);
    #1;
    chk(16'(ctrl.uart_run), 16'({sp_now[7], sp_now[3]}));
    chk(16'(ctrl.enhanced_floppy_mode2), 16'(pm_now[1]));
    chk(16'(ctrl.iface_mode), 16'(pm_now[6:5]));
    chk(16'(ctrl.second_density_output), 16'(pm_now[4] | density_in));
    chk(16'(ctrl.pin_func_game_select), 16'(pm_now[0]));
    chk(16'(ctrl.pin94_sel), 16'({pm_now[7], pm_now[2]}));
    chk(16'(ctrl.cfg_active), 16'(cfg_now));
    chk(16'(ctrl.uart_decode_en), 16'({uart2_base >= 10'h100, uart1_base >= 10'h100}));
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #50000;
    fails++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hfd92d96a));
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    sp_now = 8'h88;
    pm_now = 8'h70;
    cfg_now = 1'b0;
    check_ctrl();
    reg_rd(IDX_SER_PWR, rv);
    chk(16'(rv), 16'h0);
    enter_cfg();
    cfg_now = 1'b1;
    reg_rd(IDX_SER_PWR, rv);
    chk(16'(rv), 16'h88);
    reg_rd(IDX_PIN_MODE, rv);
    chk(16'(rv), 16'h70);
    host_rd(IDX_PORT, rv);
    chk(16'(rv), 16'(IDX_PIN_MODE));
    // Power bits, with decode boundary 0ffh/100h while powered down
    for (int k = 0; k < 12; k++) begin
      w = (k == 0) ? 8'h00 : (k == 1) ? 8'h77 : 8'($urandom);
      @(posedge core_clk) uart1_base <= (k < 2) ? 10'h0ff + 10'(k) : 10'($urandom);
      uart2_base <= (k < 2) ? 10'h100 - 10'(k) : 10'($urandom);
      reg_wr(IDX_SER_PWR, w);
      sp_now = exp_sp(w);
      check_ctrl();
      reg_rd(IDX_SER_PWR, rv);
      chk(16'(rv), 16'(sp_now));
    end
    // Pin and mode select, every interface mode and both density settings
    for (int k = 0; k < 16; k++) begin
      w = 8'($urandom);
      if (k < 4) w[6:5] = 2'(k);
      if (k < 2) w[4] = k[0];
      @(posedge core_clk) density_in <= 1'($urandom);
      reg_wr(IDX_PIN_MODE, w);
      pm_now = exp_pm(w);
      check_ctrl();
      reg_rd(IDX_PIN_MODE, rv);
      chk(16'(rv), 16'(pm_now));
    end
    // Unmapped index reads back zero and disturbs nothing
    reg_wr(8'h04, 8'hff);
    reg_rd(8'h04, rv);
    chk(16'(rv), 16'h0);
    reg_rd(IDX_SER_PWR, rv);
    chk(16'(rv), 16'(sp_now));
    // Writes after leaving config mode are dropped
    host_wr(IDX_PORT, CFG_KEY_EXIT);
    cfg_now = 1'b0;
    reg_wr(IDX_SER_PWR, ~sp_now);
    check_ctrl();
    // Host reset in config mode leaves it but keeps register contents
    enter_cfg();
    @(posedge core_clk) host_reset_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    host_reset_pin <= 1'b0;
    check_ctrl();
    reg_rd(IDX_SER_PWR, rv);
    chk(16'(rv), 16'h0);
    enter_cfg();
    cfg_now = 1'b1;
    reg_rd(IDX_SER_PWR, rv);
    chk(16'(rv), 16'(sp_now));
    reg_rd(IDX_PIN_MODE, rv);
    chk(16'(rv), 16'(pm_now));
    // Power-up reset in mid-run restores defaults
    @(posedge core_clk) arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    sp_now = 8'h88;
    pm_now = 8'h70;
    cfg_now = 1'b0;
    check_ctrl();
    tally_and_finish();
  end

endmodule

`default_nettype wire
